// ---- dv/ccs_chipset_model.sv ----
`timescale 1ns/1ps
module ccs_chipset_model (
	input  wire logic mclk_in,
	input  wire logic go_in,
	input  wire logic prio_in,
	input  wire logic snoop_ack_in,
	output logic      snoop_out,
	output logic      snoop_priority_out,
	output logic      bus_quiet_out,
	output logic      sleep_request_out
);
	// ---------------------------------------------------------------
	// snoop source, drives the snoop lines, bus quiet and a tied-low sleep request
	// ---------------------------------------------------------------
	int n = 0;
	logic g;
	logic a;
	initial begin
		snoop_out = 1'b0;
		snoop_priority_out = 1'b0;
		bus_quiet_out = 1'b1;
	end
	assign sleep_request_out = 1'b0;
	// no serial interrupt traffic and no controller clock are modelled
	always @(posedge mclk_in) begin
		g = go_in;
		a = snoop_ack_in;
		#1;
		if (g && !snoop_out) begin
			snoop_out = 1'b1;
			snoop_priority_out = prio_in;
			bus_quiet_out = 1'b0;
			n = 0;
		end else if (snoop_out) begin
			n++;
			// an unanswered snoop gives up, as a refused one never acks
			if (a || n > 4) begin
				snoop_out = 1'b0;
				snoop_priority_out = 1'b0;
				n = 0;
			end
		end else if (!bus_quiet_out && ++n > 2) begin
			bus_quiet_out = 1'b1;
		end
	end
endmodule

// ---- dv/ccs_clock_state_sva.sv ----
`timescale 1ns/1ps
module ccs_clock_state_sva #(
	parameter int LOCK_CYCLES = 20,
	parameter int EXIT_CLOCKS = 10
) (
	input  wire logic                 mclk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 stop_clock_request_in,
	input  wire logic                 halt_instruction_in,
	input  wire ccs_pkg::ccs_break_t  break_in,
	input  wire logic                 snoop_in,
	input  wire logic                 snoop_priority_in,
	input  wire logic                 bus_clock_stopped_in,
	input  wire ccs_pkg::ccs_state_t  state_out,
	input  wire ccs_pkg::ccs_status_t status_out,
	input  wire logic                 snoop_ack_out,
	input  wire logic                 interrupt_latch_en_out,
	input  wire logic                 init_pulse_out
);
	// ---------------------------------------------------------------
	// state transitions
	// ---------------------------------------------------------------
	localparam int EXIT_MAX = EXIT_CLOCKS + 2;
	localparam int LOCK_MAX = LOCK_CYCLES + 12;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	property p_halt; state_out == ccs_pkg::CCS_NORMAL && halt_instruction_in && !stop_clock_request_in
		&& !init_pulse_out |=> state_out == ccs_pkg::CCS_AUTO_HALT && status_out.halt_cycle; endproperty
	a_halt: assert property (p_halt) else $error("halt entry wrong");
	property p_stop; state_out == ccs_pkg::CCS_AUTO_HALT && stop_clock_request_in
		|=> state_out == ccs_pkg::CCS_QUICK && status_out.stop_grant_ack; endproperty
	a_stop: assert property (p_stop) else $error("stop entry wrong");
	property p_break; state_out == ccs_pkg::CCS_AUTO_HALT && break_in.nmi && !stop_clock_request_in && !snoop_in
		&& !break_in.smi && !break_in.purge |-> ##[1:EXIT_MAX] state_out == ccs_pkg::CCS_NORMAL; endproperty
	a_break: assert property (p_break) else $error("break exit late");
	property p_silent; state_out == ccs_pkg::CCS_AUTO_HALT && $past(state_out) != ccs_pkg::CCS_AUTO_HALT
		&& $past(state_out) != ccs_pkg::CCS_NORMAL |-> !status_out.halt_cycle; endproperty
	a_silent: assert property (p_silent) else $error("halt cycle on resume");
	property p_qs_hold; state_out == ccs_pkg::CCS_QUICK && stop_clock_request_in && !bus_clock_stopped_in
		&& !(snoop_in && snoop_priority_in) |=> state_out == ccs_pkg::CCS_QUICK; endproperty
	a_qs_hold: assert property (p_qs_hold) else $error("quick start left");
	property p_qs_exit; state_out == ccs_pkg::CCS_QUICK && !stop_clock_request_in && !snoop_in
		|-> ##[1:EXIT_MAX] state_out != ccs_pkg::CCS_QUICK; endproperty
	a_qs_exit: assert property (p_qs_exit) else $error("quick start exit late");
	property p_no_latch; state_out == ccs_pkg::CCS_QUICK |-> !interrupt_latch_en_out; endproperty
	a_no_latch: assert property (p_no_latch) else $error("latch in quick start");
	property p_snoop; (state_out == ccs_pkg::CCS_AUTO_HALT && snoop_in && !stop_clock_request_in)
		|| (state_out == ccs_pkg::CCS_QUICK && snoop_in && snoop_priority_in)
		|=> state_out == ccs_pkg::CCS_SNOOP && snoop_ack_out; endproperty
	a_snoop: assert property (p_snoop) else $error("snoop entry wrong");
	property p_deep_in; state_out == ccs_pkg::CCS_QUICK && bus_clock_stopped_in && !snoop_in
		|=> state_out == ccs_pkg::CCS_DEEP_SLEEP; endproperty
	a_deep_in: assert property (p_deep_in) else $error("deep sleep entry");
	property p_deep_out; $fell(bus_clock_stopped_in) && state_out == ccs_pkg::CCS_DEEP_SLEEP
		|=> (state_out == ccs_pkg::CCS_DEEP_SLEEP) [*8] ##[1:LOCK_MAX] state_out == ccs_pkg::CCS_QUICK; endproperty
	a_deep_out: assert property (p_deep_out) else $error("deep sleep exit");
endmodule
bind ccs_clock_state ccs_clock_state_sva #(.LOCK_CYCLES(LOCK_CYCLES), .EXIT_CLOCKS(EXIT_CLOCKS)) i_sva (
	.mclk_in, .rst_n_in, .stop_clock_request_in, .halt_instruction_in, .break_in, .snoop_in, .snoop_priority_in,
	.bus_clock_stopped_in, .state_out, .status_out, .snoop_ack_out, .interrupt_latch_en_out, .init_pulse_out);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, stop_clock_request_in = 1'b0, halt_instruction_in = 1'b0;
	logic smm_return_halt_in = 1'b0, smm_done_in = 1'b0, address_wrap_mask_in = 1'b0, probe_mode_request_in = 1'b0;
	logic bus_clock_stopped_in = 1'b0, snoop_go = 1'b0, snoop_prio = 1'b0;
	logic snoop_in, snoop_priority_in, bus_quiet_in, sleep_request_in;
	logic executing_out, snoop_ack_out, interrupt_latch_en_out, init_pulse_out;
	ccs_pkg::ccs_break_t  break_in = '0;
	ccs_pkg::ccs_state_t  state_out;
	ccs_pkg::ccs_status_t status_out;
	int errors = 0;
	int n_checks = 0;
	always #2 mclk_in = ~mclk_in;
	// short lock so the deep sleep exit fits the run
	ccs_clock_state #(.LOCK_CYCLES(20)) i_ccs_clock_state (.mclk_in, .rst_n_in, .stop_clock_request_in,
		.quick_start_strap_in(1'b1), .sleep_request_in, .halt_instruction_in, .break_in, .smm_return_halt_in,
		.smm_done_in, .address_wrap_mask_in, .probe_mode_request_in, .snoop_in, .snoop_priority_in, .bus_quiet_in,
		.bus_clock_stopped_in, .state_out, .status_out, .executing_out, .snoop_ack_out, .interrupt_latch_en_out,
		.init_pulse_out);
	ccs_chipset_model i_ccs_chipset_model (.mclk_in, .go_in(snoop_go), .prio_in(snoop_prio),
		.snoop_ack_in(snoop_ack_out), .snoop_out(snoop_in), .snoop_priority_out(snoop_priority_in),
		.bus_quiet_out(bus_quiet_in), .sleep_request_out(sleep_request_in));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task end_sim;
		if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wait_st(input ccs_pkg::ccs_state_t s, input int lim);
		for (int i = 0; i < lim && state_out !== s; i++) cyc(1);
		chk(state_out, s);
		if (state_out !== s) end_sim();
	endtask
	task pulse_nmi;
		break_in.nmi = 1'b1;
		cyc(1);
		break_in = '0;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_halt_quick;
		halt_instruction_in = 1'b1;
		cyc(1);
		halt_instruction_in = 1'b0;
		chk(state_out, ccs_pkg::CCS_AUTO_HALT);
		chk(status_out.halt_cycle, 1'b1);
		address_wrap_mask_in = 1'b1;
		probe_mode_request_in = 1'b1;
		cyc(2);
		chk({status_out.wrap_mask_seen, status_out.probe_seen}, 2'h3);
		stop_clock_request_in = 1'b1;
		cyc(1);
		chk(state_out, ccs_pkg::CCS_QUICK);
		chk(status_out.stop_grant_ack, 1'b1);
		pulse_nmi();
		cyc(3);
		chk(state_out, ccs_pkg::CCS_QUICK);
		chk(interrupt_latch_en_out, 1'b0);
		stop_clock_request_in = 1'b0;
		wait_st(ccs_pkg::CCS_AUTO_HALT, 12);
		chk(status_out.halt_cycle, 1'b0);
		pulse_nmi();
		wait_st(ccs_pkg::CCS_NORMAL, 12);
	endtask
	task t_breaks;
		ccs_pkg::ccs_state_t exp_st;
		for (int b = 0; b < 6; b++) begin
			halt_instruction_in = 1'b1;
			cyc(1);
			halt_instruction_in = 1'b0;
			exp_st = (b == 0) ? ccs_pkg::CCS_SMM : (b == 1) ? ccs_pkg::CCS_FLUSH : ccs_pkg::CCS_NORMAL;
			break_in = ccs_pkg::ccs_break_t'(6'h01 << b);
			cyc(1);
			break_in = '0;
			wait_st(exp_st, 12);
			if (b < 2) begin
				smm_return_halt_in = 1'b1;
				smm_done_in = (b == 0);
				cyc(1);
				smm_done_in = 1'b0;
				wait_st(ccs_pkg::CCS_AUTO_HALT, 12);
				chk(status_out.halt_cycle, 1'b0);
				pulse_nmi();
				wait_st(ccs_pkg::CCS_NORMAL, 12);
			end
		end
		halt_instruction_in = 1'b1;
		cyc(1);
		halt_instruction_in = 1'b0;
		break_in.smi = 1'b1;
		cyc(1);
		break_in = '0;
		wait_st(ccs_pkg::CCS_SMM, 2);
		smm_return_halt_in = 1'b0;
		smm_done_in = 1'b1;
		cyc(1);
		smm_done_in = 1'b0;
		wait_st(ccs_pkg::CCS_NORMAL, 3);
	endtask
	task t_snoop_deep;
		stop_clock_request_in = 1'b1;
		wait_st(ccs_pkg::CCS_QUICK, 3);
		snoop_go = 1'b1;
		cyc(1);
		snoop_go = 1'b0;
		cyc(6);
		chk(state_out, ccs_pkg::CCS_QUICK);
		snoop_go = 1'b1;
		snoop_prio = 1'b1;
		cyc(1);
		snoop_go = 1'b0;
		wait_st(ccs_pkg::CCS_SNOOP, 4);
		chk(snoop_ack_out, 1'b1);
		wait_st(ccs_pkg::CCS_QUICK, 12);
		bus_clock_stopped_in = 1'b1;
		wait_st(ccs_pkg::CCS_DEEP_SLEEP, 3);
		bus_clock_stopped_in = 1'b0;
		cyc(15);
		chk(state_out, ccs_pkg::CCS_DEEP_SLEEP);
		wait_st(ccs_pkg::CCS_QUICK, 20);
		// reset only outside deep sleep
		rst_n_in = 1'b0;
		cyc(2);
		chk(state_out, ccs_pkg::CCS_QUICK);
		rst_n_in = 1'b1;
		cyc(3);
		chk(state_out, ccs_pkg::CCS_QUICK);
		stop_clock_request_in = 1'b0;
		wait_st(ccs_pkg::CCS_NORMAL, 12);
	endtask
	initial begin
		cyc(2);
		rst_n_in = 1'b1;
		cyc(3);
		chk(state_out, ccs_pkg::CCS_NORMAL);
		chk(executing_out, 1'b1);
		t_halt_quick();
		t_breaks();
		t_snoop_deep();
		end_sim();
	end
endmodule

// ---- logic/ccs_clock_state.sv ----
`timescale 1ns/1ps
module ccs_clock_state #(
	parameter int LOCK_CYCLES = ccs_pkg::CCS_LOCK_CYCLES,
	parameter int EXIT_CLOCKS = ccs_pkg::CCS_EXIT_CLOCKS
) (
	input  wire logic                mclk_in,
	input  wire logic                rst_n_in,
	input  wire logic                stop_clock_request_in,
	input  wire logic                quick_start_strap_in,
	input  wire logic                sleep_request_in,
	input  wire logic                halt_instruction_in,
	input  wire ccs_pkg::ccs_break_t break_in,
	input  wire logic                smm_return_halt_in,
	input  wire logic                smm_done_in,
	input  wire logic                address_wrap_mask_in,
	input  wire logic                probe_mode_request_in,
	input  wire logic                snoop_in,
	input  wire logic                snoop_priority_in,
	input  wire logic                bus_quiet_in,
	input  wire logic                bus_clock_stopped_in,
	output ccs_pkg::ccs_state_t      state_out,
	output ccs_pkg::ccs_status_t     status_out,
	output logic                     executing_out,
	output logic                     snoop_ack_out,
	output logic                     interrupt_latch_en_out,
	output logic                     init_pulse_out
);
	// ---------------------------------------------------------------
	// parameter checks
	// ---------------------------------------------------------------
	initial begin
		if (EXIT_CLOCKS < 1 || EXIT_CLOCKS > 255) $error("exit clocks out of range");
		if (LOCK_CYCLES < 1 || LOCK_CYCLES > 16777215) $error("lock cycles out of range");
	end

	// ---------------------------------------------------------------
	// state record
	// ---------------------------------------------------------------
	typedef struct packed {
		ccs_pkg::ccs_state_t  st;
		ccs_pkg::ccs_state_t  prev;
		ccs_pkg::ccs_status_t stat;
		logic                 strap;
		logic                 strap_taken;
		logic                 exit_pend;
		logic [7:0]           exit_cnt;
		logic [3:0]           tail_cnt;
		logic [3:0]           flush_cnt;
		logic                 wrap_last;
		logic                 probe_last;
		logic                 lock_load;
		logic                 init;
	} ccs_regs_t;

	ccs_regs_t r_q;
	ccs_regs_t r_d;
	logic      lock_done;
	logic      brk;

	ccs_timer #(
		.WIDTH(24)
	) u_lock (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.load_in  (r_q.lock_load),
		.count_in (24'(LOCK_CYCLES)),
		.done_out (lock_done)
	);

	// reset is an input event too; in Quick Start it re-inits without leaving
	assign brk = break_in.nmi | break_in.maskable_interrupt_request | break_in.bus_init | break_in.soft_init
		| break_in.purge | break_in.smi;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.lock_load = 1'b0;
		r_d.init = 1'b0;
		r_d.stat.halt_cycle = 1'b0;
		r_d.stat.stop_grant_ack = 1'b0;
		// strap caught on the first clock after reset release
		if (!r_q.strap_taken) begin
			r_d.strap = quick_start_strap_in;
			r_d.strap_taken = 1'b1;
		end
		case (r_q.st)
			ccs_pkg::CCS_NORMAL: begin
				r_d.exit_pend = 1'b0;
				if (stop_clock_request_in) begin
					r_d.st = r_q.strap ? ccs_pkg::CCS_QUICK : ccs_pkg::CCS_STOP_GRANT;
					r_d.stat.stop_grant_ack = 1'b1;
					r_d.prev = ccs_pkg::CCS_NORMAL;
				end else if (halt_instruction_in) begin
					r_d.st = ccs_pkg::CCS_AUTO_HALT;
					r_d.stat.halt_cycle = 1'b1;
				end
			end
			ccs_pkg::CCS_AUTO_HALT: begin
				// wrap mask and probe edges are tracked here
				if (address_wrap_mask_in != r_q.wrap_last) begin
					r_d.stat.wrap_mask_seen = 1'b1;
				end
				if (probe_mode_request_in != r_q.probe_last) begin
					r_d.stat.probe_seen = 1'b1;
				end
				if (r_q.exit_pend) begin
					if (r_q.exit_cnt >= 8'(EXIT_CLOCKS - 1)) begin
						r_d.st = ccs_pkg::CCS_NORMAL;
						r_d.exit_pend = 1'b0;
					end else begin
						r_d.exit_cnt = r_q.exit_cnt + 8'h01;
					end
				end else if (stop_clock_request_in) begin
					r_d.st = r_q.strap ? ccs_pkg::CCS_QUICK : ccs_pkg::CCS_STOP_GRANT;
					r_d.stat.stop_grant_ack = 1'b1;
					r_d.prev = ccs_pkg::CCS_AUTO_HALT;
				end else if (snoop_in) begin
					r_d.st = ccs_pkg::CCS_SNOOP;
					r_d.prev = ccs_pkg::CCS_AUTO_HALT;
				end else if (break_in.smi) begin
					r_d.st = ccs_pkg::CCS_SMM;
					r_d.stat.smm_active = 1'b1;
				end else if (break_in.purge) begin
					r_d.st = ccs_pkg::CCS_FLUSH;
					r_d.stat.flush_busy = 1'b1;
					r_d.flush_cnt = 4'(ccs_pkg::CCS_FLUSH_CYCLES);
				end else if (brk) begin
					r_d.exit_pend = 1'b1;
					r_d.exit_cnt = 8'h00;
				end
			end
			ccs_pkg::CCS_SMM: begin
				if (smm_done_in) begin
					// resuming halt issues no new halt cycle
					r_d.st = smm_return_halt_in ? ccs_pkg::CCS_AUTO_HALT : ccs_pkg::CCS_NORMAL;
					r_d.stat.smm_active = 1'b0;
				end
			end
			ccs_pkg::CCS_FLUSH: begin
				if (r_q.flush_cnt == 4'h0) begin
					r_d.st = ccs_pkg::CCS_AUTO_HALT;
					r_d.stat.flush_busy = 1'b0;
				end else begin
					r_d.flush_cnt = r_q.flush_cnt - 4'h1;
				end
			end
			ccs_pkg::CCS_QUICK: begin
				// purge, bus init and interrupts are simply not looked at here
				if (r_q.exit_pend) begin
					if (r_q.exit_cnt >= 8'(EXIT_CLOCKS - 1)) begin
						r_d.st = (r_q.prev == ccs_pkg::CCS_AUTO_HALT) ? ccs_pkg::CCS_AUTO_HALT
							: ccs_pkg::CCS_NORMAL;
						r_d.exit_pend = 1'b0;
					end else begin
						r_d.exit_cnt = r_q.exit_cnt + 8'h01;
					end
				end else if (!stop_clock_request_in) begin
					r_d.exit_pend = 1'b1;
					r_d.exit_cnt = 8'h00;
				end else if (bus_clock_stopped_in) begin
					r_d.st = ccs_pkg::CCS_DEEP_SLEEP;
				end else if (snoop_in && snoop_priority_in) begin
					r_d.st = ccs_pkg::CCS_SNOOP;
					r_d.tail_cnt = 4'h0;
				end
			end
			ccs_pkg::CCS_SNOOP: begin
				if (!bus_quiet_in || snoop_in) begin
					r_d.tail_cnt = 4'h0;
				end else if (r_q.tail_cnt >= 4'(ccs_pkg::CCS_SNOOP_TAIL)) begin
					// quick start origin is folded into prev while snooping; unfold it here
					if (r_q.prev == ccs_pkg::CCS_NORMAL) begin
						r_d.st = ccs_pkg::CCS_QUICK;
					end else if (r_q.prev == ccs_pkg::CCS_QUICK) begin
						r_d.st = ccs_pkg::CCS_QUICK;
						r_d.prev = ccs_pkg::CCS_AUTO_HALT;
					end else begin
						r_d.st = r_q.prev;
					end
					r_d.tail_cnt = 4'h0;
				end else begin
					r_d.tail_cnt = r_q.tail_cnt + 4'h1;
				end
			end
			ccs_pkg::CCS_DEEP_SLEEP: begin
				// lock wait starts once the clock is seen running again
				if (!bus_clock_stopped_in && !r_q.lock_load && !r_q.exit_pend) begin
					r_d.lock_load = 1'b1;
					r_d.exit_pend = 1'b1;
				end else if (r_q.exit_pend && lock_done) begin
					r_d.st = ccs_pkg::CCS_QUICK;
					r_d.exit_pend = 1'b0;
				end
			end
			ccs_pkg::CCS_STOP_GRANT: begin
				// unsupported on this build; only a stop-clock release leaves it
				if (!stop_clock_request_in) begin
					r_d.st = ccs_pkg::CCS_NORMAL;
				end
			end
			default: begin
				r_d.st = ccs_pkg::CCS_NORMAL;
			end
		endcase
		// quick start records where it came from for the snoop return
		if (r_d.st == ccs_pkg::CCS_SNOOP && r_q.st == ccs_pkg::CCS_QUICK) begin
			r_d.prev = (r_q.prev == ccs_pkg::CCS_AUTO_HALT) ? ccs_pkg::CCS_QUICK : ccs_pkg::CCS_NORMAL;
		end
		r_d.wrap_last = address_wrap_mask_in;
		r_d.probe_last = probe_mode_request_in;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			// a held stop-clock keeps quick start through reset
			r_q.st          <= stop_clock_request_in ? ccs_pkg::CCS_QUICK : ccs_pkg::CCS_NORMAL;
			r_q.prev        <= ccs_pkg::CCS_NORMAL;
			r_q.stat        <= '0;
			r_q.strap       <= ccs_pkg::CCS_STRAP_RESET;
			r_q.strap_taken <= 1'b0;
			r_q.exit_pend   <= 1'b0;
			r_q.exit_cnt    <= 8'h00;
			r_q.tail_cnt    <= 4'h0;
			r_q.flush_cnt   <= 4'h0;
			r_q.wrap_last   <= 1'b0;
			r_q.probe_last  <= 1'b0;
			r_q.lock_load   <= 1'b0;
			r_q.init        <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign state_out = r_q.st;
	assign status_out = r_q.stat;
	assign executing_out = (r_q.st == ccs_pkg::CCS_NORMAL) && !r_q.init;
	assign snoop_ack_out = (r_q.st == ccs_pkg::CCS_SNOOP);
	assign interrupt_latch_en_out = (r_q.st == ccs_pkg::CCS_NORMAL) || (r_q.st == ccs_pkg::CCS_AUTO_HALT);
	assign init_pulse_out = r_q.init;
endmodule

// ---- logic/ccs_pkg.sv ----
// Overview of operation
// - halt instruction in Normal enters Auto Halt; clock keeps running.
// - any halt break event other than system management interrupt or cache purge returns Auto Halt to Normal.
// - stop-clock request in Auto Halt enters Quick Start, issuing stop grant acknowledge.
// - stop-clock release returns to Auto Halt with no new halt cycle.
// - system management interrupt served in Auto Halt; resume Normal or Auto Halt silently.
// - cache purge in Auto Halt flushes cache, returns to Auto Halt silently.
// - address wrap mask and probe request transitions recognised in Auto Halt.
// - quick start strap sampled at reset selects Quick Start or Stop Grant.
// - Stop Grant and Sleep unsupported; system configures Quick Start, never asserts sleep.
// - Quick Start acts only on priority-agent snoops; single processor only.
// - Quick Start leaves for Normal only on stop-clock release, within 11 clocks.
// - Quick Start latches no interrupts, ignores symmetric snoops, purge and bus init.
// - reset in Quick Start initialises but stays until stop-clock releases.
// - snoop in Auto Halt or Quick Start enters snoop state, returns after quiet.
// - stopping bus clock in Quick Start enters Deep Sleep; stop it low.
// - after clock restart, Deep Sleep returns to Quick Start after 30 ms lock.
// - Auto Halt exits to Normal within 11 clocks after a break event.
package ccs_pkg;

	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [7:0] {
		CCS_NORMAL     = 8'h01,
		CCS_AUTO_HALT  = 8'h02,
		CCS_QUICK      = 8'h04,
		CCS_SNOOP      = 8'h08,
		CCS_DEEP_SLEEP = 8'h10,
		CCS_STOP_GRANT = 8'h20,
		CCS_SMM        = 8'h40,
		CCS_FLUSH      = 8'h80
	} ccs_state_t;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CCS_CLK_MHZ        = 250;
	localparam int CCS_EXIT_CLOCKS    = 10;
	localparam int CCS_SNOOP_TAIL     = 3;
	localparam int CCS_LOCK_MS        = 30;
	// ordered so no intermediate product leaves the int range
	localparam int CCS_LOCK_CYCLES    = CCS_LOCK_MS * CCS_CLK_MHZ * 1000;
	localparam int CCS_FLUSH_CYCLES   = 4;
	localparam logic CCS_STRAP_RESET  = 1'b1;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic nmi;
		logic maskable_interrupt_request;
		logic bus_init;
		logic soft_init;
		logic purge;
		logic smi;
	} ccs_break_t;

	typedef struct packed {
		logic halt_cycle;
		logic stop_grant_ack;
		logic flush_busy;
		logic smm_active;
		logic wrap_mask_seen;
		logic probe_seen;
	} ccs_status_t;

endpackage

// ---- logic/ccs_timer.sv ----
`timescale 1ns/1ps
module ccs_timer #(
	parameter int WIDTH = 24
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	input  wire logic             load_in,
	input  wire logic [WIDTH-1:0] count_in,
	output logic                  done_out
);
	// ---------------------------------------------------------------
	// down counter
	// ---------------------------------------------------------------
	logic [WIDTH-1:0] cnt_q;
	logic             run_q;

	initial begin
		if (WIDTH < 2) $error("ccs_timer width too small");
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load_in) begin
			cnt_q <= count_in;
			run_q <= 1'b1;
		end else if (run_q && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else begin
			run_q <= 1'b0;
		end
	end

	assign done_out = run_q && (cnt_q == '0);
endmodule
